/* File: core/scs_pkg.sv */
// Package for the system clock source selection block: constants and carrier types.
package scs_pkg;

   // Core clock rate.
   localparam int CORE_CLK_MHZ = 250;

   // Start-up wait for the low speed crystal, in microseconds, and the derived core cycles.
   localparam int LXT_STARTUP_US = 1000;
   localparam int LXT_STARTUP_CYCLES = LXT_STARTUP_US * CORE_CLK_MHZ;
   localparam int LXT_CNT_W = 20;

   // Reset values of the control bits, and the system clock code that selects the low speed clock.
   localparam logic [2:0] SYS_CLK_SELECT_RST = 3'h0;
   localparam logic [2:0] SYS_CLK_SEL_LOW = 3'h7;
   localparam logic [1:0] HIGH_SPEED_RC_OSC_FREQ_RST = 2'h0;

   // Internal high speed RC frequency codes; the unused code falls back to 8 MHz.
   localparam logic [1:0] HIGH_SPEED_RC_OSC_SEL_8M = 2'h0;
   localparam logic [1:0] HIGH_SPEED_RC_OSC_SEL_12M = 2'h1;
   localparam logic [1:0] HIGH_SPEED_RC_OSC_SEL_16M = 2'h2;
   localparam logic [1:0] HIGH_SPEED_RC_OSC_SEL_8M_ALT = 2'h3;

   // Source select encodings.
   localparam logic SRC_SEL_RC = 1'b0;
   localparam logic SRC_SEL_XTAL = 1'b1;

   // Divider depth: taps for divide by 1 up to 64.
   localparam int DIV_TAPS = 7;

   // Number of gated clock outputs: cpu, high speed peripheral, low speed peripheral, watchdog.
   localparam int GATE_N = 4;

   // Software control bits.
   typedef struct packed {
      logic [2:0] sys_clk_select;
      logic high_speed_source_sel;
      logic low_speed_source_sel;
      logic high_idle_en;
      logic low_idle_en;
      logic [1:0] high_speed_rc_osc_freq_sel;
      logic low_xtal_enable;
   } scs_ctrl_t;

   // Oscillator levels, sampled on the core clock.
   typedef struct packed {
      logic high_speed_crystal_osc;
      logic high_speed_rc_osc_8m;
      logic high_speed_rc_osc_12m;
      logic high_speed_rc_osc_16m;
      logic low_speed_crystal_osc;
      logic low_speed_rc_osc;
   } scs_osc_t;

   // Switch sequencer states.
   typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_ALIGN} scs_state_t;

endpackage : scs_pkg

/* File: core/scs_hs_divider.sv */
// Divider that makes the divide by 1 to 64 taps of the high speed clock.
`timescale 1ns/1ns
module scs_hs_divider
   import scs_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic fh_in,
   output logic [DIV_TAPS-1:0] taps
);

   logic fh_prev_r;
   logic [DIV_TAPS-2:0] cnt_r;
   logic fh_rise;

   ////////////////////////////////////////////////////////////////////////////////
   // Each rising edge of the high speed clock advances the ripple count.
   assign fh_rise = fh_in & ~fh_prev_r;
   assign taps = {cnt_r, fh_prev_r};

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         fh_prev_r <= 1'b0;
         cnt_r <= '0;
      end
      else
      begin
         fh_prev_r <= fh_in;
         if (fh_rise)
         begin
            cnt_r <= cnt_r + 6'h1; // Bit k toggles at the high speed rate over 2 to the k+1.
         end
      end
   end

endmodule : scs_hs_divider

/* File: core/scs_clock_select.sv */
// System clock source selection: source muxes, divider choice, glitch-free switch and gating.
// Operation
// R1 - System clock picks high or low speed source by three-bit field, changeable live.
// R2 - Low speed source picks low crystal or low RC by one select bit.
// R3 - High speed source picks high crystal or high RC by one select bit.
// R4 - Every select encoding yields one real high and one real low source.
// R5 - High speed RC offers 8, 12 and 16 MHz selectable outputs.
// R6 - Low crystal starts when enabled and is usable only after a start-up wait.
// R7 - Halt gates the processor clock off; other clocks may keep timers running.
// R8 - Low crystal pins serve the oscillator only when enabled, else free.
// R9 - Block also supplies clocks to watchdog and time-base units.
// R10 - Low crystal gives 32.768 kHz and is chosen by the low select bit.
// R11 - Low RC gives typical 32 kHz and is chosen by the low select bit.
// R12 - Codes 000 to 110 divide high speed by 1 to 64; 111 selects low.
// R13 - Low select bit: 0 picks RC, 1 picks crystal.
// R14 - High select bit: 0 picks RC, 1 picks crystal.
// R15 - Source and ratio changes produce no truncated pulses on the system clock; only sys_clk_select is sequenced, source bits and RC code switch at once.
`timescale 1ns/1ns
module scs_clock_select
   import scs_pkg::*;
#(
   parameter logic [LXT_CNT_W-1:0] LXT_STARTUP = LXT_CNT_W'(LXT_STARTUP_CYCLES)
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire scs_ctrl_t ctrl,
   input wire scs_osc_t osc,
   input wire logic cpu_halt,
   input wire logic wdt_enable,
   output logic sys_clk_out,
   output logic cpu_clk_out,
   output logic fh_periph_clk,
   output logic timebase_clk,
   output logic wdt_clk,
   output logic lxt_ready,
   output logic low_xtal_pins_osc,
   output logic switch_busy
);

   logic high_speed_rc_osc_w;
   logic fh_w;
   logic fsub_w;
   logic [DIV_TAPS-1:0] div_taps;
   logic [7:0] clk_taps;
   logic src_cur;
   logic [2:0] cur_sel_r;
   logic [2:0] cur_sel_nxt;
   scs_state_t state_r;
   scs_state_t state_nxt;
   logic sys_clk_r;
   logic sys_clk_nxt;
   logic src_prev_r;
   logic src_fell;
   logic [LXT_CNT_W-1:0] lxt_cnt_r;
   logic lxt_ready_r;
   logic [GATE_N-1:0] gate_src;
   logic [GATE_N-1:0] gate_want;
   logic [GATE_N-1:0] gate_en_r;
   logic [GATE_N-1:0] gate_out_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Source muxes; every code maps to a running oscillator, none to silence.
   assign high_speed_rc_osc_w = (ctrl.high_speed_rc_osc_freq_sel == HIGH_SPEED_RC_OSC_SEL_12M) ? osc.high_speed_rc_osc_12m :
                   (ctrl.high_speed_rc_osc_freq_sel == HIGH_SPEED_RC_OSC_SEL_16M) ? osc.high_speed_rc_osc_16m :
                   osc.high_speed_rc_osc_8m; // R5 R4
   assign fh_w = (ctrl.high_speed_source_sel == SRC_SEL_XTAL) ?
                 osc.high_speed_crystal_osc : high_speed_rc_osc_w; // R3 R14
   // The crystal is only taken once it has started; until then the RC stands in.
   assign fsub_w = (ctrl.low_speed_source_sel == SRC_SEL_XTAL && lxt_ready_r) ?
                   osc.low_speed_crystal_osc : osc.low_speed_rc_osc; // R2 R13 R10 R11 R4

   scs_hs_divider u_div
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .fh_in(fh_w),
      .taps(div_taps)
   );

   // Code 111 is the low speed clock, the lower codes the divider taps.
   assign clk_taps = {fsub_w, div_taps}; // R12
   assign src_cur = clk_taps[cur_sel_r]; // R1
   // A fall of the chosen source; a bare low level may be the last cycle of its low phase.
   assign src_fell = src_prev_r & ~src_cur; // R15

   ////////////////////////////////////////////////////////////////////////////////
   // Switch sequencer: finish the present high phase, then wait for the new source to fall.
   // Waiting for a fall keeps the output low for at least a full low phase of the new source.
   always_comb
   begin
      state_nxt = state_r;
      cur_sel_nxt = cur_sel_r;
      sys_clk_nxt = src_cur;
      unique case (state_r)
         ST_RUN:
         begin
            if (ctrl.sys_clk_select != cur_sel_r)
            begin
               state_nxt = ST_DRAIN; // R1
            end
         end
         ST_DRAIN:
         begin
            if (!src_cur)
            begin
               cur_sel_nxt = ctrl.sys_clk_select; // R15
               state_nxt = ST_ALIGN;
            end
         end
         ST_ALIGN:
         begin
            sys_clk_nxt = 1'b0; // R15
            if (src_fell)
            begin
               state_nxt = ST_RUN; // R15
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         state_r <= ST_RUN;
         cur_sel_r <= SYS_CLK_SELECT_RST;
         sys_clk_r <= 1'b0;
         src_prev_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cur_sel_r <= cur_sel_nxt;
         sys_clk_r <= sys_clk_nxt;
         src_prev_r <= src_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Low crystal start-up count; restarts whenever the enable is dropped.
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         lxt_cnt_r <= '0;
         lxt_ready_r <= 1'b0;
      end
      else if (!ctrl.low_xtal_enable)
      begin
         lxt_cnt_r <= '0; // R6
         lxt_ready_r <= 1'b0;
      end
      else if (lxt_cnt_r != LXT_STARTUP)
      begin
         lxt_cnt_r <= lxt_cnt_r + 20'h0_0001; // R6
      end
      else
      begin
         lxt_ready_r <= 1'b1; // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Gated clocks: an enable only changes while its output would be low.
   assign gate_src = {osc.low_speed_rc_osc, fsub_w, fh_w, sys_clk_nxt}; // R9
   assign gate_want = {wdt_enable, ~cpu_halt | ctrl.low_idle_en,
                       ~cpu_halt | ctrl.high_idle_en, ~cpu_halt}; // R7 R9

   genvar gi;
   generate
      for (gi = 0; gi < GATE_N; gi++)
      begin : g_gate
         always_ff @(posedge core_clk)
         begin
            if (!nrst)
            begin
               gate_en_r[gi] <= 1'b0;
               gate_out_r[gi] <= 1'b0;
            end
            else
            begin
               if (!gate_src[gi])
               begin
                  gate_en_r[gi] <= gate_want[gi]; // R7
               end
               gate_out_r[gi] <= gate_src[gi] & gate_en_r[gi]; // R7 R9
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign sys_clk_out = sys_clk_r;
   assign cpu_clk_out = gate_out_r[0];
   assign fh_periph_clk = gate_out_r[1];
   assign timebase_clk = gate_out_r[2];
   assign wdt_clk = gate_out_r[3];
   assign lxt_ready = lxt_ready_r;
   assign low_xtal_pins_osc = ctrl.low_xtal_enable; // R8
   assign switch_busy = (state_r != ST_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   run_follow_a: assert property (@(posedge core_clk) disable iff (!nrst) // R1
      (state_r == ST_RUN) |=> (sys_clk_r == $past(src_cur)))
      else $error("System clock does not follow the chosen source.");

   low_sel_a: assert property (@(posedge core_clk) disable iff (!nrst) // R13
      (ctrl.low_speed_source_sel == SRC_SEL_RC) |-> (fsub_w == osc.low_speed_rc_osc))
      else $error("Low select zero did not pick the RC.");

   high_sel_a: assert property (@(posedge core_clk) disable iff (!nrst) // R14
      (ctrl.high_speed_source_sel == SRC_SEL_XTAL) |-> (fh_w == osc.high_speed_crystal_osc))
      else $error("High select one did not pick the crystal.");

   high_speed_rc_osc_alt_a: assert property (@(posedge core_clk) disable iff (!nrst) // R5
      (ctrl.high_speed_rc_osc_freq_sel == HIGH_SPEED_RC_OSC_SEL_8M_ALT) |-> (high_speed_rc_osc_w == osc.high_speed_rc_osc_8m))
      else $error("Spare RC code did not give 8 MHz.");

   lxt_wait_a: assert property (@(posedge core_clk) disable iff (!nrst) // R6
      $rose(ctrl.low_xtal_enable) |-> !lxt_ready_r [*8])
      else $error("Low crystal ready too soon after enable.");

   pins_free_a: assert property (@(posedge core_clk) disable iff (!nrst) // R8
      !low_xtal_pins_osc |=> !lxt_ready_r)
      else $error("Crystal in use while its pins are released.");

   cpu_gate_a: assert property (@(posedge core_clk) disable iff (!nrst) // R7
      !gate_en_r[0] |=> !cpu_clk_out)
      else $error("Processor clock runs while gated.");

   wdt_off_a: assert property (@(posedge core_clk) disable iff (!nrst) // R9
      (!wdt_enable && !osc.low_speed_rc_osc) |=> ##1 !wdt_clk)
      else $error("Watchdog clock runs while disabled.");

   low_code_a: assert property (@(posedge core_clk) disable iff (!nrst) // R12
      (state_r == ST_RUN && cur_sel_r == SYS_CLK_SEL_LOW) |=> (sys_clk_r == $past(fsub_w)))
      else $error("Code 111 did not give the low speed clock.");

   sel_change_a: assert property (@(posedge core_clk) disable iff (!nrst) // R15
      (cur_sel_r != $past(cur_sel_r)) |-> (!sys_clk_r && state_r == ST_ALIGN))
      else $error("Source changed while the system clock was high.");

   switch_done_c: cover property (@(posedge core_clk) disable iff (!nrst)
      (state_r == ST_ALIGN) ##1 (state_r == ST_RUN));
   halt_c: cover property (@(posedge core_clk) disable iff (!nrst)
      cpu_halt ##1 !gate_en_r[0]);
   lxt_ready_c: cover property (@(posedge core_clk) disable iff (!nrst)
      $rose(lxt_ready_r));

endmodule : scs_clock_select

/* File: tb/tb_system_clock_source_select.sv */
// Bench for the clock source selection block: periods, gating, crystal start-up and switching.
`timescale 1ns/1ns
module tb_system_clock_source_select;
   import scs_pkg::*;

   logic core_clk, nrst, cpu_halt, wdt_enable, glitch_chk, last_sys;
   scs_ctrl_t ctrl;
   scs_osc_t osc;
   logic sys_clk_out, cpu_clk_out, fh_periph_clk, timebase_clk, wdt_clk;
   logic lxt_ready, low_xtal_pins_osc, switch_busy;
   int errors, n_tests, cyc, run_len, p, k;
   int hp[4] = '{12, 10, 6, 12};

   // Observed clocks: 4 cpu, 3 system, 2 fast peripheral, 1 time-base, 0 watchdog.
   wire [4:0] obs = {cpu_clk_out, sys_clk_out, fh_periph_clk, timebase_clk, wdt_clk};

   // The start-up count is shortened so the crystal becomes ready in a few cycles.
   scs_clock_select #(.LXT_STARTUP(20'h0_0014)) scs_clock_select_inst (
      .core_clk(core_clk), .nrst(nrst), .ctrl(ctrl), .osc(osc), .cpu_halt(cpu_halt),
      .wdt_enable(wdt_enable), .sys_clk_out(sys_clk_out), .cpu_clk_out(cpu_clk_out),
      .fh_periph_clk(fh_periph_clk), .timebase_clk(timebase_clk), .wdt_clk(wdt_clk),
      .lxt_ready(lxt_ready), .low_xtal_pins_osc(low_xtal_pins_osc),
      .switch_busy(switch_busy));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Core clock of 4 ns.
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   function automatic logic sq(input int h);
      return ((cyc / h) % 2) == 1;
   endfunction : sq

   // Oscillators as square waves with distinct half periods in core cycles.
   always @(posedge core_clk)
   begin
      #1;
      cyc = cyc + 1;
      osc = {sq(4), sq(6), sq(5), sq(3), sq(20), sq(24)};
   end

   // Flags any system clock pulse shorter than the fastest source half period.
   always @(posedge core_clk)
   begin
      #1;
      if (!glitch_chk)
         run_len = 99;
      else if (sys_clk_out !== last_sys)
      begin
         check("sys pulse width", 16'(run_len >= 3), 16'h0001);
         run_len = 1;
      end
      else
         run_len = run_len + 1;
      last_sys = sys_clk_out;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : check

   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   // Waits for a rising edge of one observed clock and returns the cycles it took.
   task rise(input int idx, output int n);
      logic prev;
      prev = obs[idx];
      for (n = 1; n < 3000; n++)
      begin
         step(1);
         if (prev === 1'b0 && obs[idx] === 1'b1)
            break;
         prev = obs[idx];
      end
   endtask : rise

   // Measures one full period after letting two edges settle any transient.
   task chk_per(input string what, input int idx, input int exp);
      rise(idx, p);
      rise(idx, p);
      rise(idx, p);
      check(what, 16'(p), 16'(exp));
   endtask : chk_per

   // Counts high cycles of one observed clock over 120 cycles.
   task highs(input int idx, output int n);
      n = 0;
      repeat (120)
      begin
         step(1);
         n = n + int'(obs[idx] === 1'b1);
      end
   endtask : highs

   // Changes the system clock code, expects busy, then waits for the switch to end.
   task sel(input logic [2:0] code);
      ctrl.sys_clk_select = code;
      step(1);
      check("switch busy", 16'(switch_busy), 16'h0001);
      for (k = 0; k < 3000 && switch_busy !== 1'b0; k++)
         step(1);
      check("switch finished", 16'(switch_busy), 16'h0000);
   endtask : sel

   task results;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the expected run of about 6000 cycles.
   initial
   begin
      #200000;
      errors++;
      $display("watchdog expired");
      results();
   end

   // Main sequence of tests.
   initial
   begin
      errors = 0;
      n_tests = 0;
      cyc = 0;
      glitch_chk = 1'b0;
      nrst = 1'b0;
      cpu_halt = 1'b0;
      wdt_enable = 1'b0;
      ctrl = '0;
      osc = '0;
      step(10);
      check("sys clock in reset", 16'(sys_clk_out), 16'h0000);
      check("ready in reset", 16'(lxt_ready), 16'h0000);
      nrst = 1'b1;
      for (int f = 0; f < 4; f++)
      begin
         ctrl.high_speed_rc_osc_freq_sel = 2'(f);
         chk_per("rc period", 3, hp[f]);
      end
      $display("test rc frequencies done");
      ctrl.high_speed_source_sel = SRC_SEL_XTAL;
      for (int c = 6; c >= 0; c--)
      begin
         sel(3'(c));
         chk_per("divided period", 3, 8 << c);
      end
      chk_per("fast peripheral period", 2, 8);
      $display("test divide codes done");
      sel(SYS_CLK_SEL_LOW);
      chk_per("low rc period", 3, 48);
      ctrl.low_speed_source_sel = SRC_SEL_XTAL;
      chk_per("unready crystal period", 3, 48);
      check("pins free", 16'(low_xtal_pins_osc), 16'h0000);
      ctrl.low_xtal_enable = 1'b1;
      step(5);
      check("pins used", 16'(low_xtal_pins_osc), 16'h0001);
      check("not yet ready", 16'(lxt_ready), 16'h0000);
      step(30);
      check("ready", 16'(lxt_ready), 16'h0001);
      chk_per("crystal period", 3, 40);
      ctrl.low_xtal_enable = 1'b0;
      step(2);
      check("ready dropped", 16'(lxt_ready), 16'h0000);
      $display("test low sources done");
      ctrl.low_speed_source_sel = SRC_SEL_RC;
      sel(3'h0);
      {wdt_enable, ctrl.low_idle_en, cpu_halt} = 3'b111;
      step(4);
      highs(4, p);
      check("halted cpu highs", 16'(p), 16'h0000);
      highs(2, p);
      check("idle fast peripheral highs", 16'(p), 16'h0000);
      chk_per("time-base period", 1, 48);
      chk_per("watchdog period", 0, 48);
      ctrl.high_idle_en = 1'b1;
      chk_per("idle fast peripheral period", 2, 8);
      wdt_enable = 1'b0;
      step(60);
      highs(0, p);
      check("stopped watchdog highs", 16'(p), 16'h0000);
      cpu_halt = 1'b0;
      chk_per("running cpu period", 4, 8);
      $display("test halt gating done");
      ctrl.high_speed_source_sel = SRC_SEL_RC;
      ctrl.high_speed_rc_osc_freq_sel = HIGH_SPEED_RC_OSC_SEL_16M;
      step(20);
      glitch_chk = 1'b1;
      sel(3'h3);
      sel(3'h0);
      sel(SYS_CLK_SEL_LOW);
      ctrl.sys_clk_select = 3'h5;
      step(1);
      sel(3'h2);
      chk_per("latest code period", 3, 24);
      glitch_chk = 1'b0;
      $display("test live switching done");
      results();
   end

endmodule : tb_system_clock_source_select
